// ==== src/rfcb_bank.sv ====
// AXI4-Lite bank of checksum, synthesizer, spacing and sync setup bytes.
//
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "rfcb_consts.svh"

module rfcb_bank #(
  parameter int ADDR_W = 8
) (
  input  wire logic              clk,
  input  wire logic              reset,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output var  logic              s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output var  logic              s_axi_wready,
  output var  rfcb_pkg::rfcb_resp_e s_axi_bresp,
  output var  logic              s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output var  logic              s_axi_arready,
  output var  logic [31:0]       s_axi_rdata,
  output var  rfcb_pkg::rfcb_resp_e s_axi_rresp,
  output var  logic              s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output var  logic [30:0]       checksumGeneratorCoeffs,
  output var  logic [5:0]        txSynthIntegerCount,
  output var  logic [19:0]       txSynthFractionCount,
  output var  logic [5:0]        rxSynthIntegerCount,
  output var  logic [19:0]       rxSynthFractionCount,
  output var  logic [15:0]       channelStep,
  output var  logic [5:0]        syncPatternBits
);
  import rfcb_pkg::*;

  localparam int WORD_W = ADDR_W - 2;

  // Reset values in slot order, slot 0 being the lowest index.
  localparam rfcb_byte_t RESET_TABLE [`RFCB_REG_COUNT] = '{
    `RFCB_RST_COEFF_30_24, `RFCB_RST_COEFF_23_16, `RFCB_RST_COEFF_15_8,
    `RFCB_RST_COEFF_7_0,   `RFCB_RST_SPARE,       `RFCB_RST_TX_INT,
    `RFCB_RST_TX_FRAC_HI,  `RFCB_RST_TX_FRAC_MID, `RFCB_RST_TX_FRAC_LO,
    `RFCB_RST_RX_INT,      `RFCB_RST_RX_FRAC_HI,  `RFCB_RST_RX_FRAC_MID,
    `RFCB_RST_RX_FRAC_LO,  `RFCB_RST_STEP_HI,     `RFCB_RST_STEP_LO,
    `RFCB_RST_SYNC_LEN
  };

  rfcb_wr_e          wrState;
  rfcb_wr_e          next_wrState;
  rfcb_rd_e          rdState;
  rfcb_rd_e          next_rdState;
  logic [ADDR_W-1:0] heldAddr;
  rfcb_byte_t        heldData;
  logic              heldStrb;
  rfcb_byte_t        regFile [`RFCB_REG_COUNT];

  // Address decode: word aligned and inside the bank's index range.
  function automatic logic inBank(input logic [ADDR_W-1:0] addr);
    logic [WORD_W-1:0] word;
    word = addr[ADDR_W-1:2];
    return (addr[1:0] == 2'h0) &&
           (word >= WORD_W'(`RFCB_IDX_FIRST)) &&
           (word <= WORD_W'(`RFCB_IDX_LAST));
  endfunction : inBank

  function automatic logic [3:0] slotOf(input logic [ADDR_W-1:0] addr);
    logic [WORD_W-1:0] diff;
    diff = addr[ADDR_W-1:2] - WORD_W'(`RFCB_IDX_FIRST);
    return diff[3:0];
  endfunction : slotOf

  // Write channel handshakes; address and data may come in either order.
  wire logic awTake   = s_axi_awvalid && s_axi_awready;
  wire logic wTake    = s_axi_wvalid && s_axi_wready;
  wire logic haveAddr = awTake || (wrState == WR_ADDR);
  wire logic haveData = wTake || (wrState == WR_DATA);
  wire logic doWrite  = haveAddr && haveData && (wrState != WR_RESP);

  // The commit uses the held half when one arrived earlier.
  wire logic [ADDR_W-1:0] commitAddr = (wrState == WR_ADDR) ? heldAddr
                                                            : s_axi_awaddr;
  wire rfcb_byte_t commitData = (wrState == WR_DATA) ? heldData
                                                     : s_axi_wdata[7:0];
  wire logic commitStrb = (wrState == WR_DATA) ? heldStrb : s_axi_wstrb[0];
  wire logic commitHit  = inBank(commitAddr);
  wire logic [3:0] commitSlot = slotOf(commitAddr);
  // Only byte lane 0 carries data; upper lanes are ignored.
  wire logic storeByte  = doWrite && commitHit && commitStrb;

  // Read decode.
  wire logic arTake = s_axi_arvalid && s_axi_arready;
  wire logic readHit = inBank(s_axi_araddr);
  wire logic [3:0] readSlot = slotOf(s_axi_araddr);

  // Ready and valid come straight from the state.
  assign s_axi_awready = (wrState == WR_IDLE) || (wrState == WR_DATA);
  assign s_axi_wready  = (wrState == WR_IDLE) || (wrState == WR_ADDR);
  assign s_axi_bvalid  = (wrState == WR_RESP);
  assign s_axi_arready = (rdState == RD_IDLE);
  assign s_axi_rvalid  = (rdState == RD_DATA);

  // Next write state.
  always_comb begin
    next_wrState = wrState;
    unique case (wrState)
      WR_IDLE: begin
        if (doWrite) begin
          next_wrState = WR_RESP;
        end else if (awTake) begin
          next_wrState = WR_ADDR;
        end else if (wTake) begin
          next_wrState = WR_DATA;
        end
      end
      WR_ADDR, WR_DATA: begin
        if (doWrite) begin
          next_wrState = WR_RESP;
        end
      end
      WR_RESP: begin
        if (s_axi_bready) begin
          next_wrState = WR_IDLE;
        end
      end
    endcase
  end

  // Next read state.
  assign next_rdState = (rdState == RD_IDLE) ? (arTake ? RD_DATA : RD_IDLE)
                                             : (s_axi_rready ? RD_IDLE
                                                             : RD_DATA);

  // Write side: hold the first half, answer once both have been taken.
  always_ff @(posedge clk) begin
    if (reset) begin
      wrState     <= WR_IDLE;
      heldAddr    <= '0;
      heldData    <= 8'h00;
      heldStrb    <= 1'b0;
      s_axi_bresp <= RFCB_OKAY;
    end else begin
      wrState <= next_wrState;
      if (awTake) begin
        heldAddr <= s_axi_awaddr;
      end
      if (wTake) begin
        heldData <= s_axi_wdata[7:0];
        heldStrb <= s_axi_wstrb[0];
      end
      if (doWrite) begin
        s_axi_bresp <= commitHit ? RFCB_OKAY : RFCB_SLVERR;
      end
    end
  end

  // Read side: unmapped reads return zero with a slave error.
  always_ff @(posedge clk) begin
    if (reset) begin
      rdState     <= RD_IDLE;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RFCB_OKAY;
    end else begin
      rdState <= next_rdState;
      if (arTake) begin
        s_axi_rdata <= readHit ? {24'h00_0000, regFile[readSlot]}
                               : 32'h0000_0000;
        s_axi_rresp <= readHit ? RFCB_OKAY : RFCB_SLVERR;
      end
    end
  end

  // Storage, one byte register per index; every bit is kept as written.
  for (genvar i = 0; i < `RFCB_REG_COUNT; i++) begin : g_reg
    rfcb_byte_reg #(
      .RESET_VALUE (RESET_TABLE[i])
    ) u_reg (
      .clk       (clk),
      .reset     (reset),
      .writeEn   (storeByte && (commitSlot == 4'(i))),
      .writeData (commitData),
      .value     (regFile[i])
    );
  end

  // Assembled values; reserved bits are simply not routed anywhere.
  assign checksumGeneratorCoeffs = {
    regFile[`RFCB_SLOT(`RFCB_IDX_COEFF_30_24)][`RFCB_COEFF_TOP_MSB:0],
    regFile[`RFCB_SLOT(`RFCB_IDX_COEFF_23_16)],
    regFile[`RFCB_SLOT(`RFCB_IDX_COEFF_15_8)],
    regFile[`RFCB_SLOT(`RFCB_IDX_COEFF_7_0)]
  };
  assign txSynthIntegerCount =
    regFile[`RFCB_SLOT(`RFCB_IDX_TX_INT)][`RFCB_INT_MSB:0];
  assign txSynthFractionCount = {
    regFile[`RFCB_SLOT(`RFCB_IDX_TX_FRAC_HI)][`RFCB_FRAC_HI_MSB:0],
    regFile[`RFCB_SLOT(`RFCB_IDX_TX_FRAC_MID)],
    regFile[`RFCB_SLOT(`RFCB_IDX_TX_FRAC_LO)]
  };
  assign rxSynthIntegerCount =
    regFile[`RFCB_SLOT(`RFCB_IDX_RX_INT)][`RFCB_INT_MSB:0];
  assign rxSynthFractionCount = {
    regFile[`RFCB_SLOT(`RFCB_IDX_RX_FRAC_HI)][`RFCB_FRAC_HI_MSB:0],
    regFile[`RFCB_SLOT(`RFCB_IDX_RX_FRAC_MID)],
    regFile[`RFCB_SLOT(`RFCB_IDX_RX_FRAC_LO)]
  };
  assign channelStep = {
    regFile[`RFCB_SLOT(`RFCB_IDX_STEP_HI)],
    regFile[`RFCB_SLOT(`RFCB_IDX_STEP_LO)]
  };

  // The length clamp acts on the usable value only.
  rfcb_sync_clamp u_clamp (
    .clk     (clk),
    .reset   (reset),
    .rawBits (regFile[`RFCB_SLOT(`RFCB_IDX_SYNC_LEN)][`RFCB_SYNC_MSB:0]),
    .effBits (syncPatternBits)
  );

  // Helper strobes for the checks below.
  wire logic wrSpare = storeByte &&
                       (commitSlot == `RFCB_SLOT(`RFCB_IDX_SPARE));
  wire logic wrTop   = storeByte &&
                       (commitSlot == `RFCB_SLOT(`RFCB_IDX_COEFF_30_24));
  wire logic wrRxInt = storeByte &&
                       (commitSlot == `RFCB_SLOT(`RFCB_IDX_RX_INT));
  wire logic wrSync  = storeByte &&
                       (commitSlot == `RFCB_SLOT(`RFCB_IDX_SYNC_LEN));

  property p_coeff_reset;
    @(posedge clk) disable iff (reset)
      $fell(reset) |-> checksumGeneratorCoeffs[23:0] ==
        {`RFCB_RST_COEFF_23_16, `RFCB_RST_COEFF_15_8, `RFCB_RST_COEFF_7_0};
  endproperty
  a_coeff_reset: assert property (p_coeff_reset)
    else $error("Coefficient bytes wrong after reset.");

  property p_coeff_top;
    @(posedge clk) disable iff (reset)
      wrTop |=> checksumGeneratorCoeffs[30:24] == $past(commitData[6:0]);
  endproperty
  a_coeff_top: assert property (p_coeff_top)
    else $error("Top coefficient bits did not follow the write.");

  property p_tx_int_reset;
    @(posedge clk) disable iff (reset)
      $fell(reset) |-> txSynthIntegerCount == 6'(`RFCB_RST_TX_INT);
  endproperty
  a_tx_int_reset: assert property (p_tx_int_reset)
    else $error("Transmit integer count wrong after reset.");

  property p_tx_frac_reset;
    @(posedge clk) disable iff (reset)
      $fell(reset) |-> txSynthFractionCount == {4'(`RFCB_RST_TX_FRAC_HI),
        `RFCB_RST_TX_FRAC_MID, `RFCB_RST_TX_FRAC_LO};
  endproperty
  a_tx_frac_reset: assert property (p_tx_frac_reset)
    else $error("Transmit fraction wrong after reset.");

  property p_rx_int_write;
    @(posedge clk) disable iff (reset)
      wrRxInt |=> rxSynthIntegerCount == $past(commitData[5:0]) &&
                  $stable(txSynthIntegerCount);
  endproperty
  a_rx_int_write: assert property (p_rx_int_write)
    else $error("Receive integer count not separate from transmit.");

  property p_rx_frac_reset;
    @(posedge clk) disable iff (reset)
      $fell(reset) |-> rxSynthFractionCount == {4'(`RFCB_RST_RX_FRAC_HI),
        `RFCB_RST_RX_FRAC_MID, `RFCB_RST_RX_FRAC_LO};
  endproperty
  a_rx_frac_reset: assert property (p_rx_frac_reset)
    else $error("Receive fraction wrong after reset.");

  property p_step_reset;
    @(posedge clk) disable iff (reset)
      $fell(reset) |-> channelStep == {`RFCB_RST_STEP_HI, `RFCB_RST_STEP_LO};
  endproperty
  a_step_reset: assert property (p_step_reset)
    else $error("Channel step wrong after reset.");

  property p_sync_reset;
    @(posedge clk) disable iff (reset)
      $fell(reset) |-> syncPatternBits == 6'(`RFCB_RST_SYNC_LEN);
  endproperty
  a_sync_reset: assert property (p_sync_reset)
    else $error("Sync length wrong after reset.");

  property p_sync_low;
    @(posedge clk) disable iff (reset)
      wrSync && commitData[5:0] < `RFCB_SYNC_MIN |->
        ##2 syncPatternBits == `RFCB_SYNC_MIN;
  endproperty
  a_sync_low: assert property (p_sync_low)
    else $error("Short sync length was not raised to the minimum.");

  property p_sync_high;
    @(posedge clk) disable iff (reset)
      wrSync && commitData[5:0] > `RFCB_SYNC_MAX |->
        ##2 syncPatternBits == `RFCB_SYNC_MAX;
  endproperty
  a_sync_high: assert property (p_sync_high)
    else $error("Long sync length was not clamped to the maximum.");

  property p_spare_inert;
    @(posedge clk) disable iff (reset)
      wrSpare |=> $stable(checksumGeneratorCoeffs) &&
                  $stable(txSynthFractionCount) && $stable(channelStep);
  endproperty
  a_spare_inert: assert property (p_spare_inert)
    else $error("Spare byte write changed a setup value.");

  property p_write_answer;
    @(posedge clk) disable iff (reset)
      doWrite |=> s_axi_bvalid &&
        s_axi_bresp == (($past(commitHit)) ? RFCB_OKAY : RFCB_SLVERR);
  endproperty
  a_write_answer: assert property (p_write_answer)
    else $error("Write response missing or wrong.");
endmodule : rfcb_bank
`default_nettype wire

// ==== src/rfcb_byte_reg.sv ====
// One byte-wide read/write setup register with its own reset value.
`timescale 1ns/1ps
`default_nettype none
module rfcb_byte_reg #(
  parameter rfcb_pkg::rfcb_byte_t RESET_VALUE = 8'h00
) (
  input  wire logic                clk,
  input  wire logic                reset,
  input  wire logic                writeEn,
  input  wire rfcb_pkg::rfcb_byte_t writeData,
  output var  rfcb_pkg::rfcb_byte_t value
);
  import rfcb_pkg::*;

  // All eight bits are stored so reserved bits read back as written.
  always_ff @(posedge clk) begin
    if (reset) begin
      value <= RESET_VALUE;
    end else if (writeEn) begin
      value <= writeData;
    end
  end
endmodule : rfcb_byte_reg
`default_nettype wire

// ==== src/rfcb_consts.svh ====
// Register offsets, reset values, field positions and limits of the bank.
`ifndef RFCB_CONSTS_SVH
`define RFCB_CONSTS_SVH

// Register indices; the byte address on the bus is four times the index.
`define RFCB_IDX_COEFF_30_24 6'h16
`define RFCB_IDX_COEFF_23_16 6'h17
`define RFCB_IDX_COEFF_15_8  6'h18
`define RFCB_IDX_COEFF_7_0   6'h19
`define RFCB_IDX_SPARE       6'h1A
`define RFCB_IDX_TX_INT      6'h1B
`define RFCB_IDX_TX_FRAC_HI  6'h1C
`define RFCB_IDX_TX_FRAC_MID 6'h1D
`define RFCB_IDX_TX_FRAC_LO  6'h1E
`define RFCB_IDX_RX_INT      6'h1F
`define RFCB_IDX_RX_FRAC_HI  6'h20
`define RFCB_IDX_RX_FRAC_MID 6'h21
`define RFCB_IDX_RX_FRAC_LO  6'h22
`define RFCB_IDX_STEP_HI     6'h23
`define RFCB_IDX_STEP_LO     6'h24
`define RFCB_IDX_SYNC_LEN    6'h25
`define RFCB_IDX_FIRST       `RFCB_IDX_COEFF_30_24
`define RFCB_IDX_LAST        `RFCB_IDX_SYNC_LEN
`define RFCB_REG_COUNT       16
`define RFCB_SLOT(idx)       4'((idx) - `RFCB_IDX_FIRST)

// Reset values, one per register.
`define RFCB_RST_COEFF_30_24 8'h00
`define RFCB_RST_COEFF_23_16 8'h00
`define RFCB_RST_COEFF_15_8  8'h1E
`define RFCB_RST_COEFF_7_0   8'hB2
`define RFCB_RST_SPARE       8'h00
`define RFCB_RST_TX_INT      8'h21
`define RFCB_RST_TX_FRAC_HI  8'h06
`define RFCB_RST_TX_FRAC_MID 8'hBD
`define RFCB_RST_TX_FRAC_LO  8'h0B
`define RFCB_RST_RX_INT      8'h21
`define RFCB_RST_RX_FRAC_HI  8'h06
`define RFCB_RST_RX_FRAC_MID 8'hBD
`define RFCB_RST_RX_FRAC_LO  8'h0B
`define RFCB_RST_STEP_HI     8'h09
`define RFCB_RST_STEP_LO     8'h73
`define RFCB_RST_SYNC_LEN    8'h20

// Field positions inside the partial registers.
`define RFCB_COEFF_TOP_MSB   6
`define RFCB_INT_MSB         5
`define RFCB_FRAC_HI_MSB     3
`define RFCB_SYNC_MSB        5

// Limits applied to the sync pattern length.
`define RFCB_SYNC_MIN        6'h08
`define RFCB_SYNC_MAX        6'h20

`endif

// ==== src/rfcb_pkg.sv ====
// Types shared by the channel setup bank and its helper modules.
`default_nettype none
package rfcb_pkg;
  typedef logic [7:0] rfcb_byte_t;
  typedef enum logic [1:0] {
    RFCB_OKAY   = 2'h0,
    RFCB_SLVERR = 2'h2
  } rfcb_resp_e;
  // Gray codes along idle, one half held, response.
  typedef enum logic [1:0] {
    WR_IDLE = 2'h0,
    WR_ADDR = 2'h1,
    WR_RESP = 2'h3,
    WR_DATA = 2'h2
  } rfcb_wr_e;
  typedef enum logic {
    RD_IDLE = 1'h0,
    RD_DATA = 1'h1
  } rfcb_rd_e;
endpackage : rfcb_pkg
`default_nettype wire

// ==== src/rfcb_sync_clamp.sv ====
// Registered clamp of the sync pattern length into its usable range.
`timescale 1ns/1ps
`default_nettype none
`include "rfcb_consts.svh"
module rfcb_sync_clamp (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic [5:0] rawBits,
  output var  logic [5:0] effBits
);
  import rfcb_pkg::*;

  // Out-of-range settings act as the nearest limit; the register keeps them.
  wire logic [5:0] next_effBits = (rawBits < `RFCB_SYNC_MIN) ? `RFCB_SYNC_MIN :
                                  (rawBits > `RFCB_SYNC_MAX) ? `RFCB_SYNC_MAX :
                                  rawBits;

  // The extra flop keeps the output a clean register at a cycle of latency.
  always_ff @(posedge clk) begin
    if (reset) begin
      effBits <= 6'(`RFCB_RST_SYNC_LEN);
    end else begin
      effBits <= next_effBits;
    end
  end
endmodule : rfcb_sync_clamp
`default_nettype wire

// ==== tb/rfcb_bank_test.sv ====
// Self-checking bench for the channel setup register bank.
`timescale 1ns/1ps
`default_nettype none
module rfcb_bank_test;
  import rfcb_pkg::*;
  logic        clk      = 1'b0;
  logic        reset    = 1'b1;
  logic [7:0]  awAddr   = 8'h00;
  logic        awValid  = 1'b0;
  logic        awReady;
  logic [31:0] wData    = 32'h0;
  logic [3:0]  wStrb    = 4'h0;
  logic        wValid   = 1'b0;
  logic        wReady;
  rfcb_resp_e  bResp;
  logic        bValid;
  logic        bReady   = 1'b0;
  logic [7:0]  arAddr   = 8'h00;
  logic        arValid  = 1'b0;
  logic        arReady;
  logic [31:0] rData;
  rfcb_resp_e  rResp;
  logic        rValid;
  logic        rReady   = 1'b0;
  logic [30:0] coeffs;
  logic [5:0]  txInt;
  logic [19:0] txFrac;
  logic [5:0]  rxInt;
  logic [19:0] rxFrac;
  logic [15:0] step;
  logic [5:0]  syncBits;
  int          failures = 0;
  int          checks   = 0;
  logic [7:0]  shadow   [16];
  logic [7:0]  resetTbl [16] = '{8'h00, 8'h00, 8'h1E, 8'hB2, 8'h00, 8'h21,
    8'h06, 8'hBD, 8'h0B, 8'h21, 8'h06, 8'hBD, 8'h0B, 8'h09, 8'h73, 8'h20};
  // Short, exact limits, inside, above and reserved bits set on both sides.
  logic [7:0]  syncTbl  [8] = '{8'h00, 8'h07, 8'h08, 8'h14, 8'h20, 8'h21,
    8'hFF, 8'hC6};

  // Expected outputs are assembled from the bench's own copy of the bytes.
  wire logic [30:0] expCoeffs = {shadow[0][6:0], shadow[1], shadow[2],
    shadow[3]};
  wire logic [19:0] expTxFrac = {shadow[6][3:0], shadow[7], shadow[8]};
  wire logic [19:0] expRxFrac = {shadow[10][3:0], shadow[11], shadow[12]};
  wire logic [15:0] expStep   = {shadow[13], shadow[14]};

  rfcb_bank #(.ADDR_W(8)) rfcb_bank_i (
    .clk                     (clk),
    .reset                   (reset),
    .s_axi_awaddr            (awAddr),
    .s_axi_awvalid           (awValid),
    .s_axi_awready           (awReady),
    .s_axi_wdata             (wData),
    .s_axi_wstrb             (wStrb),
    .s_axi_wvalid            (wValid),
    .s_axi_wready            (wReady),
    .s_axi_bresp             (bResp),
    .s_axi_bvalid            (bValid),
    .s_axi_bready            (bReady),
    .s_axi_araddr            (arAddr),
    .s_axi_arvalid           (arValid),
    .s_axi_arready           (arReady),
    .s_axi_rdata             (rData),
    .s_axi_rresp             (rResp),
    .s_axi_rvalid            (rValid),
    .s_axi_rready            (rReady),
    .checksumGeneratorCoeffs (coeffs),
    .txSynthIntegerCount     (txInt),
    .txSynthFractionCount    (txFrac),
    .rxSynthIntegerCount     (rxInt),
    .rxSynthFractionCount    (rxFrac),
    .channelStep             (step),
    .syncPatternBits         (syncBits)
  );

  // Free-running 250 MHz clock.
  initial begin
    forever #2 clk = ~clk;
  end

  // Byte address of a register slot; the bus sees four times the index.
  function automatic logic [7:0] addr_of(input int i);
    return 8'((8'h16 + 8'(i)) << 2);
  endfunction : addr_of

  // The length the sync detector should act on for a written field.
  function automatic logic [5:0] clamp_len(input logic [5:0] raw);
    if (raw < 6'h08) return 6'h08;
    if (raw > 6'h20) return 6'h20;
    return raw;
  endfunction : clamp_len

  task automatic final_report();
    if (failures == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : final_report

  // Every mismatch is reported and counted on the spot.
  task automatic cmp_data(input logic [31:0] got, input logic [31:0] exp,
                          input string what);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what,
               got, exp);
    end
  endtask : cmp_data

  task automatic cmp_resp(input rfcb_resp_e got, input rfcb_resp_e exp,
                          input string what);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what,
               got, exp);
    end
  endtask : cmp_resp

  // Idle cycles ahead of the request vary the spacing between writes.
  // Address and data are offered together and each drops once taken.
  task automatic axi_write(input logic [7:0] addr, input logic [7:0] data,
                           input logic [3:0] strb, input int idleGap,
                           input rfcb_resp_e expResp);
    bit awDone;
    bit wDone;
    awDone = 1'b0;
    wDone = 1'b0;
    repeat (idleGap + 1) @(posedge clk);
    awAddr  <= addr;
    awValid <= 1'b1;
    wData   <= {24'h000000, data};
    wStrb   <= strb;
    wValid  <= 1'b1;
    bReady  <= 1'b1;
    while (!(awDone && wDone)) begin
      @(posedge clk);
      if (awValid && awReady === 1'b1) begin
        awDone = 1'b1;
        awValid <= 1'b0;
      end
      if (wValid && wReady === 1'b1) begin
        wDone = 1'b1;
        wValid <= 1'b0;
      end
    end
    do @(posedge clk); while (bValid !== 1'b1);
    cmp_resp(bResp, expResp, "write response");
    bReady <= 1'b0;
  endtask : axi_write

  task automatic axi_read(input logic [7:0] addr, input logic [7:0] expData,
                          input rfcb_resp_e expResp);
    @(posedge clk);
    arAddr  <= addr;
    arValid <= 1'b1;
    rReady  <= 1'b1;
    do @(posedge clk); while (arReady !== 1'b1);
    arValid <= 1'b0;
    do @(posedge clk); while (rValid !== 1'b1);
    cmp_data(rData, {24'h000000, expData}, "read data");
    cmp_resp(rResp, expResp, "read response");
    rReady <= 1'b0;
  endtask : axi_read

  // Reset for ten cycles; the copy of the bytes returns to its defaults.
  task automatic do_reset();
    reset <= 1'b1;
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    for (int i = 0; i < 16; i++) shadow[i] = resetTbl[i];
  endtask : do_reset

  // The sync length lags one cycle, so look a little after the edge.
  task automatic check_outputs();
    #1;
    cmp_data(32'(coeffs), 32'(expCoeffs), "coeffs");
    cmp_data(32'(txInt), 32'(shadow[5][5:0]), "tx int");
    cmp_data(32'(txFrac), 32'(expTxFrac), "tx frac");
    cmp_data(32'(rxInt), 32'(shadow[9][5:0]), "rx int");
    cmp_data(32'(rxFrac), 32'(expRxFrac), "rx frac");
    cmp_data(32'(step), 32'(expStep), "step");
    cmp_data(32'(syncBits), 32'(clamp_len(shadow[15][5:0])), "sync");
  endtask : check_outputs

  // Generous limit: the whole sequence needs well under a thousand cycles.
  initial begin
    repeat (5000) @(posedge clk);
    failures++;
    final_report();
  end

  initial begin
    do_reset();
    check_outputs();
    for (int i = 0; i < 16; i++) begin
      axi_read(addr_of(i), resetTbl[i], RFCB_OKAY);
    end
    // Every byte but the sync length gets a pattern with reserved bits set, except the transmit fraction high byte (0x09).
    for (int i = 0; i < 15; i++) begin
      shadow[i] = 8'(8'hA7 + i * 8'h3B);
      axi_write(addr_of(i), shadow[i], 4'hF, i % 3, RFCB_OKAY);
    end
    for (int i = 0; i < 16; i++) begin
      axi_read(addr_of(i), shadow[i], RFCB_OKAY);
    end
    check_outputs();
    // A write with the low lane disabled leaves the byte alone.
    axi_write(addr_of(5), 8'h3C, 4'hE, 0, RFCB_OKAY);
    axi_read(addr_of(5), shadow[5], RFCB_OKAY);
    // Neighbours of the bank and a misaligned address are refused.
    axi_write(8'h54, 8'h5A, 4'hF, 0, RFCB_SLVERR);
    axi_write(8'h98, 8'h5A, 4'hF, 1, RFCB_SLVERR);
    axi_write(8'h59, 8'h5A, 4'hF, 0, RFCB_SLVERR);
    axi_read(8'h54, 8'h00, RFCB_SLVERR);
    axi_read(8'h98, 8'h00, RFCB_SLVERR);
    axi_read(8'h59, 8'h00, RFCB_SLVERR);
    check_outputs();
    // Sync length: the register keeps the value, the output is clamped.
    for (int j = 0; j < 8; j++) begin
      shadow[15] = syncTbl[j];
      axi_write(addr_of(15), shadow[15], 4'hF, 0, RFCB_OKAY);
      check_outputs();
      axi_read(addr_of(15), shadow[15], RFCB_OKAY);
    end
    // A second reset in mid-run brings every default back.
    do_reset();
    check_outputs();
    axi_read(addr_of(0), 8'h00, RFCB_OKAY);
    axi_read(addr_of(15), 8'h20, RFCB_OKAY);
    final_report();
  end
endmodule : rfcb_bank_test
`default_nettype wire
